// File: core/mndp_buf2.v
`timescale 1ns/100ps
// Two-entry buffer with valid/ready on both sides.
module mndp_buf2 #(
   parameter W = 11
) (
   // Clock and reset.
   input  wire         i_clk,
   input  wire         i_srst,
   // Fill side.
   input  wire         i_in_valid,
   output wire         o_in_ready,
   input  wire [W-1:0] i_in_data,
   // Drain side.
   output wire         o_out_valid,
   input  wire         i_out_ready,
   output wire [W-1:0] o_out_data
);

   reg [W-1:0] mem_reg [0:1];
   reg         wr_ptr_reg;
   reg         rd_ptr_reg;
   reg [1:0]   cnt_reg;
   wire        push;
   wire        pop;

   // Full and empty come straight from the occupancy count.
   assign o_in_ready  = (cnt_reg != 2'h2);
   assign o_out_valid = (cnt_reg != 2'h0);
   assign o_out_data  = mem_reg[rd_ptr_reg];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   // Pointers and count; a push and a pop together leave the count alone.
   always @(posedge i_clk) begin
      if (i_srst) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         cnt_reg    <= 2'h0;
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
            wr_ptr_reg          <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         if (push & ~pop) begin
            cnt_reg <= cnt_reg + 2'h1;
         end else if (pop & ~push) begin
            cnt_reg <= cnt_reg - 2'h1;
         end
      end
   end

endmodule

// File: core/mndp_regs.vh
`ifndef MNDP_REGS_VH
`define MNDP_REGS_VH

// Clock rates in kHz.
`define MNDP_SYS_CLK_KHZ   125000
`define MNDP_FAST_CLK_KHZ  25000
`define MNDP_SLOW_CLK_KHZ  2500

// Line symbol kinds carried beside each buffered byte.
`define MNDP_KIND_W        3
`define MNDP_KIND_IDLE     3'h0
`define MNDP_KIND_J        3'h1
`define MNDP_KIND_K        3'h2
`define MNDP_KIND_T        3'h3
`define MNDP_KIND_R        3'h4
`define MNDP_KIND_DATA     3'h5
`define MNDP_KIND_ERR      3'h6

// Nibble shown with the error flag on a false carrier.
`define MNDP_FALSE_CARRIER 4'he

`endif

// File: core/mndp_top.v
`timescale 1ns/100ps
`include "mndp_regs.vh"
// Nibble data path of the PHY side of the media independent interface.
module mndp_top (
   // Clock and reset.
   input  wire       i_clk,
   input  wire       i_srst,
   // Device configuration, same clock domain.
   input  wire       i_speed_100,
   input  wire       i_link_up,
   // Decoded line receive stream, one byte or delimiter per entry.
   input  wire       i_line_valid,
   output wire       o_line_ready,
   input  wire [2:0] i_line_kind,
   input  wire [7:0] i_line_byte,
   // Receive pins toward the MAC.
   output reg        o_rx_clk,
   output reg  [3:0] o_rxd,
   output reg        o_rx_dv,
   output reg        o_rx_er,
   output wire       o_rx_er_oe_n,
   input  wire       i_receive_tristate_control,
   output wire       o_rx_clk_from_line,
   // Transmit pins from the MAC.
   output reg        o_tx_clk,
   input  wire       i_tx_en,
   input  wire [3:0] i_txd,
   // Transmit bytes toward the line coder.
   output reg  [7:0] o_tx_byte,
   output reg        o_tx_byte_valid,
   output reg        o_tx_active
);

   localparam DIV_FAST = `MNDP_SYS_CLK_KHZ / `MNDP_FAST_CLK_KHZ;
   localparam DIV_SLOW = `MNDP_SYS_CLK_KHZ / `MNDP_SLOW_CLK_KHZ;
   localparam [5:0] DIV_FAST_W = DIV_FAST[5:0];
   localparam [5:0] DIV_SLOW_W = DIV_SLOW[5:0];

   localparam [3:0] S_IDLE  = 4'h1;
   localparam [3:0] S_JSEEN = 4'h2;
   localparam [3:0] S_FRAME = 4'h4;
   localparam [3:0] S_TSEEN = 4'h8;

   ////////////////////////////////////////////////////////////////////////////
   // Interface clock divider.

   reg  [5:0] div_cnt_reg;
   reg        link_d_reg;
   wire [5:0] div_len;
   wire       clk_rise;
   wire       realign;

   assign div_len  = i_speed_100 ? DIV_FAST_W : DIV_SLOW_W;
   // A realign cycle may also sit at count zero but raises no clock, so it is no tick.
   assign clk_rise = (div_cnt_reg == 6'h00) & ~realign;
   // A fresh 100 Mb/s link restarts the phase, as a recovered clock would.
   assign realign  = i_speed_100 & i_link_up & ~link_d_reg;
   assign o_rx_clk_from_line = i_speed_100 & i_link_up;

   // Counter wraps at the divide length; a change to the fast speed wraps it at once if the count is at or past the new end.
   always @(posedge i_clk) begin
      if (i_srst) begin
         div_cnt_reg <= 6'h00;
         link_d_reg  <= 1'b0;
         o_rx_clk    <= 1'b0;
         o_tx_clk    <= 1'b0;
      end else begin
         link_d_reg <= i_link_up;
         if (realign || div_cnt_reg >= div_len - 6'h01) begin
            div_cnt_reg <= 6'h00;
         end else begin
            div_cnt_reg <= div_cnt_reg + 6'h01;
         end
         // Both clocks rise at the edge that ends the tick, the same edge that moves the receive outputs.
         o_rx_clk <= (div_cnt_reg < (div_len >> 1)) & ~realign;
         o_tx_clk <= (div_cnt_reg < (div_len >> 1)) & ~realign;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive buffer; a slow MAC side stalls the line through o_line_ready.

   wire        buf_valid;
   wire [10:0] buf_data;
   reg         buf_pop;
   wire [2:0]  kind;
   wire [7:0]  rbyte;

   mndp_buf2 #(
      .W (11)
   ) u_rx_buf (
      .i_clk       (i_clk),
      .i_srst      (i_srst),
      .i_in_valid  (i_line_valid),
      .o_in_ready  (o_line_ready),
      .i_in_data   ({i_line_kind, i_line_byte}),
      .o_out_valid (buf_valid),
      .i_out_ready (buf_pop),
      .o_out_data  (buf_data)
   );

   assign kind  = buf_data[10:8];
   assign rbyte = buf_data[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // Receive framing state machine.

   reg [3:0] rx_state_reg;
   reg [3:0] rx_state_next;
   reg       half_reg;
   reg       half_next;
   reg [3:0] rxd_next;
   reg       dv_next;
   reg       er_next;
   reg       er_oe_n_s1_reg;
   reg       er_oe_n_s2_reg;

   // One symbol is judged per receive clock rise; data bytes take two rises.
   always @* begin
      rx_state_next = rx_state_reg;
      half_next     = half_reg;
      rxd_next      = 4'h0;
      dv_next       = 1'b0;
      er_next       = 1'b0;
      buf_pop       = 1'b0;
      if (clk_rise && buf_valid) begin
         buf_pop = 1'b1;
         case (rx_state_reg)
            S_IDLE: begin
               if (!i_speed_100 && kind == `MNDP_KIND_DATA) begin
                  rx_state_next = S_FRAME;
                  rxd_next      = rbyte[3:0];
                  dv_next       = 1'b1;
                  half_next     = 1'b1;
                  buf_pop       = 1'b0;
               end else if (i_speed_100 && kind == `MNDP_KIND_J) begin
                  rx_state_next = S_JSEEN;
               end else if (i_speed_100 && kind != `MNDP_KIND_IDLE) begin
                  rxd_next = `MNDP_FALSE_CARRIER;
                  er_next  = 1'b1;
               end
            end
            S_JSEEN: begin
               if (kind == `MNDP_KIND_K) begin
                  rx_state_next = S_FRAME;
               end else begin
                  rx_state_next = S_IDLE;
                  rxd_next      = `MNDP_FALSE_CARRIER;
                  er_next       = 1'b1;
               end
            end
            S_FRAME: begin
               if (kind == `MNDP_KIND_DATA) begin
                  // Low nibble first, then the high nibble pops the entry.
                  rxd_next  = half_reg ? rbyte[7:4] : rbyte[3:0];
                  dv_next   = 1'b1;
                  half_next = ~half_reg;
                  buf_pop   = half_reg;
               end else if (i_speed_100 && kind == `MNDP_KIND_T) begin
                  rx_state_next = S_TSEEN;
               end else if (i_speed_100 && kind != `MNDP_KIND_IDLE) begin
                  // Flag the fault with valid, then drop valid at the next rise.
                  rx_state_next = S_IDLE;
                  dv_next       = 1'b1;
                  er_next       = 1'b1;
               end else begin
                  rx_state_next = S_IDLE;
               end
            end
            S_TSEEN: begin
               rx_state_next = S_IDLE;
            end
            default: begin
               rx_state_next = S_IDLE;
            end
         endcase
      end
   end

   // Outputs move only on the tick that raises the receive clock.
   always @(posedge i_clk) begin
      if (i_srst) begin
         rx_state_reg <= S_IDLE;
         half_reg     <= 1'b0;
         o_rxd        <= 4'h0;
         o_rx_dv      <= 1'b0;
         o_rx_er      <= 1'b0;
      end else begin
         rx_state_reg <= rx_state_next;
         half_reg     <= half_next;
         if (clk_rise) begin
            o_rxd   <= rxd_next;
            o_rx_dv <= dv_next;
            o_rx_er <= er_next & i_speed_100;
         end
      end
   end

   // The tristate control is a pin, so it is synchronised before use.
   always @(posedge i_clk) begin
      if (i_srst) begin
         er_oe_n_s1_reg <= 1'b1;
         er_oe_n_s2_reg <= 1'b1;
      end else begin
         er_oe_n_s1_reg <= i_receive_tristate_control;
         er_oe_n_s2_reg <= er_oe_n_s1_reg;
      end
   end
   assign o_rx_er_oe_n = er_oe_n_s2_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Transmit sampling; pins pass two flip-flops first.

   reg [3:0] txd_s1_reg;
   reg [3:0] txd_s2_reg;
   reg       txen_s1_reg;
   reg       txen_s2_reg;
   reg       tx_half_reg;
   reg [3:0] tx_low_reg;

   always @(posedge i_clk) begin
      if (i_srst) begin
         txd_s1_reg  <= 4'h0;
         txd_s2_reg  <= 4'h0;
         txen_s1_reg <= 1'b0;
         txen_s2_reg <= 1'b0;
      end else begin
         txd_s1_reg  <= i_txd;
         txd_s2_reg  <= txd_s1_reg;
         txen_s1_reg <= i_tx_en;
         txen_s2_reg <= txen_s1_reg;
      end
   end

   // The synchronised value at the rise is what the pins held just before it.
   always @(posedge i_clk) begin
      if (i_srst) begin
         tx_half_reg     <= 1'b0;
         tx_low_reg      <= 4'h0;
         o_tx_byte       <= 8'h00;
         o_tx_byte_valid <= 1'b0;
         o_tx_active     <= 1'b0;
      end else begin
         o_tx_byte_valid <= 1'b0;
         if (clk_rise) begin
            o_tx_active <= txen_s2_reg;
            if (txen_s2_reg) begin
               if (tx_half_reg) begin
                  o_tx_byte       <= {txd_s2_reg, tx_low_reg};
                  o_tx_byte_valid <= 1'b1;
               end else begin
                  tx_low_reg <= txd_s2_reg;
               end
               tx_half_reg <= ~tx_half_reg;
            end else begin
               // A lone trailing nibble is dropped when enable falls.
               tx_half_reg <= 1'b0;
            end
         end
      end
   end

endmodule

// File: testbench/mndp_checker.sv
`timescale 1ns/100ps
// Watches the pins of the nibble data path toward the MAC.
module mndp_checker (
   // Clock, reset and mode.
   input logic       i_clk,
   input logic       i_srst,
   input logic       i_speed_100,
   input logic       i_link_up,
   input logic       i_receive_tristate_control,
   // Pins toward the MAC.
   input logic       o_rx_clk,
   input logic [3:0] o_rxd,
   input logic       o_rx_dv,
   input logic       o_rx_er,
   input logic       o_rx_er_oe_n,
   input logic       o_rx_clk_from_line,
   input logic       o_tx_clk,
   input logic       o_tx_byte_valid
);
   // Speed only changes under reset, so every clock period seen here is whole.
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);
   fast_period_a: assert property ($rose(o_rx_clk) && i_speed_100 |-> ##5 $rose(o_rx_clk))
      else $error("Fast receive clock period wrong.");
   fast_high_a: assert property ($rose(o_rx_clk) && i_speed_100 |-> o_rx_clk[*2] ##1 !o_rx_clk)
      else $error("Fast receive clock high time wrong.");
   slow_period_a: assert property ($rose(o_rx_clk) && !i_speed_100 |-> ##50 $rose(o_rx_clk))
      else $error("Slow receive clock period wrong.");
   tx_clk_same_a: assert property (o_tx_clk == o_rx_clk)
      else $error("Transmit clock differs from receive clock.");
   rxd_sync_a: assert property ($changed(o_rxd) |-> $rose(o_rx_clk))
      else $error("Receive nibble moved off a clock rise.");
   dv_sync_a: assert property ($changed(o_rx_dv) |-> $rose(o_rx_clk))
      else $error("Data valid moved off a clock rise.");
   er_sync_a: assert property ($changed(o_rx_er) |-> $rose(o_rx_clk))
      else $error("Receive error moved off a clock rise.");
   er_slow_a: assert property (!i_speed_100 |-> !o_rx_er)
      else $error("Receive error raised at slow speed.");
   er_gate_a: assert property (o_rx_er_oe_n == $past(i_receive_tristate_control, 2))
      else $error("Receive error enable does not follow its control.");
   line_src_a: assert property (o_rx_clk_from_line == (i_speed_100 && i_link_up))
      else $error("Receive clock source flag wrong.");
   byte_pulse_a: assert property (o_tx_byte_valid |=> !o_tx_byte_valid)
      else $error("Transmit byte strobe longer than one cycle.");
   // Main scenarios.
   cover property ($rose(o_rx_dv));
   cover property ($rose(o_rx_er));
   cover property (o_tx_byte_valid);
endmodule
bind mndp_top mndp_checker u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_speed_100(i_speed_100),
   .i_link_up(i_link_up), .i_receive_tristate_control(i_receive_tristate_control), .o_rx_clk(o_rx_clk),
   .o_rxd(o_rxd), .o_rx_dv(o_rx_dv), .o_rx_er(o_rx_er), .o_rx_er_oe_n(o_rx_er_oe_n),
   .o_rx_clk_from_line(o_rx_clk_from_line), .o_tx_clk(o_tx_clk), .o_tx_byte_valid(o_tx_byte_valid));

// File: testbench/mndp_mac_model.sv
`timescale 1ns/100ps
// Behavioural MAC on the far side of the nibble pins.
module mndp_mac_model (
   // Bench system clock.
   input  logic       i_clk,
   // Receive pins from the device.
   input  logic       i_rx_clk,
   input  logic [3:0] i_rxd,
   input  logic       i_rx_dv,
   input  logic       i_rx_er,
   // Transmit pins toward the device.
   input  logic       i_tx_clk,
   output logic       o_tx_en = 1'b0,
   output logic [3:0] o_txd = 4'h0
);
   logic [7:0] rxq[$];
   logic       er_seen = 1'b0, er_dv = 1'b0, half = 1'b0, clk_q = 1'b0;
   logic [3:0] er_nib = 4'h0, low_nib = 4'h0;
   // Pins change on the clock rise, so look half a cycle later when settled.
   always @(negedge i_clk) begin
      if (i_rx_clk && !clk_q) begin
         if (i_rx_er) begin
            er_seen = 1'b1;
            er_nib  = i_rxd;
            er_dv   = i_rx_dv;
         end
         if (i_rx_dv && half) begin
            rxq.push_back({i_rxd, low_nib});
            half = 1'b0;
         end else begin
            low_nib = i_rxd;
            half    = i_rx_dv;
         end
      end
      clk_q = i_rx_clk;
   end
   // Two bytes, one nibble per transmit clock rise; the released bus shows the inverse.
   task tx2(input logic [15:0] w);
      integer i;
      begin
         for (i = 0; i < 5; i = i + 1) begin
            @(posedge i_tx_clk);
            @(negedge i_clk);
            o_tx_en = (i < 4);
            o_txd   = (i < 4) ? w[4*i +: 4] : ~o_txd;
         end
      end
   endtask
endmodule

// File: testbench/tb_mndp_top.sv
`timescale 1ns/100ps
// Self-checking bench for the nibble data path.
module tb_mndp_top;
   logic       clk = 1'b0, srst = 1'b1, speed = 1'b1, link = 1'b1, vld = 1'b0, tric = 1'b1, refused = 1'b0;
   logic [2:0] kind = 3'h0;
   logic [7:0] byt = 8'h00;
   wire        tx_en, rdy, rx_clk, rx_dv, rx_er, oe_n, tx_clk, bvalid, active;
   wire  [3:0] txd, rxd;
   wire  [7:0] tx_byte;
   logic [7:0] txq[$];
   integer     error_cnt = 0, tests_run = 0;
   // System clock of 8 ns.
   always #4 clk = ~clk;
   mndp_top DUT (.i_clk(clk), .i_srst(srst), .i_speed_100(speed), .i_link_up(link), .i_line_valid(vld),
      .o_line_ready(rdy), .i_line_kind(kind), .i_line_byte(byt), .o_rx_clk(rx_clk), .o_rxd(rxd), .o_rx_dv(rx_dv),
      .o_rx_er(rx_er), .o_rx_er_oe_n(oe_n), .i_receive_tristate_control(tric), .o_rx_clk_from_line(),
      .o_tx_clk(tx_clk), .i_tx_en(tx_en), .i_txd(txd), .o_tx_byte(tx_byte), .o_tx_byte_valid(bvalid),
      .o_tx_active(active));
   mndp_mac_model mac (.i_clk(clk), .i_rx_clk(rx_clk), .i_rxd(rxd), .i_rx_dv(rx_dv), .i_rx_er(rx_er),
      .i_tx_clk(tx_clk), .o_tx_en(tx_en), .o_txd(txd));
   // Collect transmit bytes and note whether the buffer ever pushed back.
   always @(posedge clk) begin
      if (bvalid === 1'b1) txq.push_back(tx_byte);
      if (rdy === 1'b0) refused = 1'b1;
   end
   task summarize;
      begin
         $display("checks %0d errors %0d", tests_run, error_cnt);
         if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // Speed and link only change under reset, which restarts the dividers cleanly.
   task reset_to(input logic s, input logic l);
      begin
         @(negedge clk);
         srst = 1'b1; speed = s; link = l;
         repeat (2) @(negedge clk);
         srst = 1'b0;
      end
   endtask
   // Offer one entry and hold it until the edge at which ready is high.
   task put(input logic [2:0] k, input logic [7:0] b);
      integer n;
      begin
         @(negedge clk);
         vld = 1'b1; kind = k; byt = b;
         for (n = 0; n < 500 && rdy !== 1'b1; n = n + 1) @(negedge clk);
         @(posedge clk);
      end
   endtask
   task idle;
      begin
         @(negedge clk);
         vld = 1'b0; kind = 3'h0; byt = ~byt;
      end
   endtask
   task until_dv(input logic v);
      integer n;
      for (n = 0; n < 2000 && rx_dv !== v; n = n + 1) @(negedge clk);
   endtask
   task clear_mac;
      begin
         mac.rxq.delete(); mac.er_seen = 1'b0; refused = 1'b0;
      end
   endtask
   task rx_frame;
      begin
         clear_mac;
         put(3'h1, 8'h00); put(3'h2, 8'h00); put(3'h5, 8'ha5); put(3'h5, 8'h3c); put(3'h3, 8'h00); put(3'h4, 8'h00);
         idle; until_dv(1'b1); until_dv(1'b0);
         chk("rx count", 16'h0002, 16'(mac.rxq.size()));
         chk("rx byte0", 16'h00a5, 16'(mac.rxq[0]));
         chk("rx byte1", 16'h003c, 16'(mac.rxq[1]));
         chk("rx error", 16'h0000, 16'(mac.er_seen));
         chk("buffer refused", 16'h0001, 16'(refused));
      end
   endtask
   task false_carrier;
      integer n;
      begin
         clear_mac;
         put(3'h2, 8'h00); idle;
         for (n = 0; n < 200 && mac.er_seen !== 1'b1; n = n + 1) @(negedge clk);
         chk("fc error", 16'h0001, 16'(mac.er_seen));
         chk("fc nibble", 16'h000e, 16'(mac.er_nib));
         chk("fc valid", 16'h0000, 16'(mac.er_dv));
      end
   endtask
   task frame_err;
      begin
         clear_mac;
         put(3'h1, 8'h00); put(3'h2, 8'h00); put(3'h5, 8'h77); put(3'h6, 8'h00);
         idle; until_dv(1'b1); until_dv(1'b0);
         chk("frame error", 16'h0001, 16'(mac.er_seen));
         chk("error in frame", 16'h0001, 16'(mac.er_dv));
      end
   endtask
   task tristate;
      begin
         @(negedge clk);
         tric = 1'b0;
         repeat (3) @(negedge clk);
         chk("er enable on", 16'h0000, 16'(oe_n));
         tric = 1'b1;
         repeat (3) @(negedge clk);
         chk("er enable off", 16'h0001, 16'(oe_n));
      end
   endtask
   task tx_pair;
      integer n;
      begin
         txq.delete();
         mac.tx2(16'hc35a);
         for (n = 0; n < 200 && active !== 1'b0; n = n + 1) @(negedge clk);
         chk("tx count", 16'h0002, 16'(txq.size()));
         chk("tx byte0", 16'h005a, 16'(txq[0]));
         chk("tx byte1", 16'h00c3, 16'(txq[1]));
         chk("tx active", 16'h0000, 16'(active));
      end
   endtask
   // At slow speed a data entry opens the frame and a non-data entry closes it.
   task slow_mode;
      begin
         clear_mac;
         put(3'h6, 8'h00); put(3'h5, 8'h96); put(3'h0, 8'h00); idle;
         until_dv(1'b1); until_dv(1'b0);
         chk("slow count", 16'h0001, 16'(mac.rxq.size()));
         chk("slow byte", 16'h0096, 16'(mac.rxq[0]));
         chk("slow error", 16'h0000, 16'(mac.er_seen));
      end
   endtask
   // The whole run needs under a thousand cycles; a hang is cut off at 50000 cycles.
   initial begin
      #400000;
      error_cnt = error_cnt + 1;
      summarize;
   end
   initial begin
      reset_to(1'b1, 1'b1);
      rx_frame;
      false_carrier;
      frame_err;
      tristate;
      tx_pair;
      reset_to(1'b0, 1'b0);
      slow_mode;
      tx_pair;
      summarize;
   end
endmodule
